// ==== pkg/bcds_defines.svh ====
// Purpose: constants of the break cycle data strobe block
// Assumes: 10 MHz clk, processor phase pulses arrive from pins
// Notes: shared by package, design and bench
`ifndef BCDS_DEFINES_SVH
`define BCDS_DEFINES_SVH
`define BCDS_WORD_W 18
`define BCDS_ADDR_W 15
`define BCDS_WORD_RST 18'h0_0000
`define BCDS_ADDR_RST 15'h0000
`endif

// ==== pkg/bcds_pkg.sv ====
`include "bcds_defines.svh"
package bcds_pkg;
	typedef logic [`BCDS_WORD_W-1:0] bcds_word_t;
	typedef logic [`BCDS_ADDR_W-1:0] bcds_addr_t;
	typedef enum logic [1:0] {
		BCDS_IDLE = 2'b00,
		BCDS_SYNC = 2'b01,
		BCDS_BRK  = 2'b11
	} bcds_state_t;
	typedef struct packed {
		logic p1;
		logic p2;
		logic p3;
		logic p5;
	} bcds_phase_t;
	typedef struct packed {
		bcds_state_t st;
		bcds_phase_t s1;
		bcds_phase_t s2;
		bcds_phase_t s3;
		logic        req1;
		logic        req2;
		logic        dir1;
		logic        dir2;
		logic        dir_in;
		logic        strobed;
		bcds_word_t  word;
		bcds_addr_t  loc;
		bcds_addr_t  a1;
		bcds_addr_t  a2;
		bcds_word_t  w1;
		bcds_word_t  w2;
		logic        in_stb;
		logic        out_stb;
		logic        addr_stb;
		logic        wr;
		logic        brk_rq;
	} bcds_st_t;
endpackage

// ==== verification/bcds_far_end.sv ====
// Purpose: far end device of the break port
// Assumes: bench commands the request
// Notes: lines go inverted while no request is held
module bcds_far_end
	import bcds_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       go,
	input  wire bcds_word_t w,
	input  wire logic       stb,
	input  wire bcds_word_t bwo,
	output logic            rq = 1'h0,
	output bcds_word_t      dl = 18'h0_0000,
	output bcds_word_t      cap
);
timeunit 1ns;
timeprecision 1ns;
always @(posedge clk)
begin
	rq <= go;
	dl <= go ? w : ~w;
end
always @(posedge clk)
	if (stb)
		cap <= bwo;
endmodule

// ==== verification/bcds_strobes_monitor.sv ====
// Purpose: port checks of the break strobe block
// Assumes: bench holds direction over a break, and data only up to its phase three
// Notes: word load may lag its strobe by one cycle
module bcds_strobes_monitor
	import bcds_pkg::*;
(
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       dir_into_memory,
	input wire bcds_word_t inbound_word_lines,
	input wire bcds_addr_t ext_address,
	input wire logic       address_taken_pulse,
	input wire logic       inbound_word_strobe,
	input wire logic       outbound_word_strobe,
	input wire logic       core_write_start,
	input wire bcds_addr_t core_location_reg,
	input wire bcds_word_t buffered_word_outputs
);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
wire logic i = inbound_word_strobe;
wire logic o = outbound_word_strobe;
wire logic d = dir_into_memory;
wire bcds_word_t b = buffered_word_outputs;
a_one_strobe: assert property (!(i && o)) else $error("both");
a_in_dir: assert property (i |-> d) else $error("in dir");
a_out_dir: assert property (o |-> !d) else $error("out dir");
a_in_pulse: assert property (i |=> !i) else $error("in wide");
a_word_load: assert property (
	i |-> ##[0:1] b == inbound_word_lines) else $error("load");
a_word_hold: assert property ($changed(b) |-> i || $past(i))
	else $error("hold");
a_addr_load: assert property (address_taken_pulse |->
	##[0:1] core_location_reg == ext_address) else $error("addr");
a_write_dir: assert property (core_write_start |-> d) else $error("wr");
cover property (i);
cover property (o);
cover property (core_write_start);
endmodule

// ==== verification/tb_bcds_strobes.sv ====
// Purpose: bench of the break strobe block
// Assumes: phases are wide pulses, 8 cycles apart
// Notes: strobes are counted, not sampled in place
`include "bcds_defines.svh"
module tb_bcds_strobes import bcds_pkg::*;;
timeunit 1ns;
timeprecision 1ns;
logic clk = 0, resetn = 0, instr_done = 0, go = 0, dir_into_memory = 0;
logic [3:0] p = 0;
wire logic phase_one_pulse = p[0], phase_two_pulse = p[1];
wire logic phase_three_pulse = p[2], phase_five_pulse = p[3];
logic break_request, address_taken_pulse, inbound_word_strobe;
logic outbound_word_strobe, core_write_start, transfer_request_level;
bcds_word_t w = 0, inbound_word_lines, buffered_word_outputs, cap;
bcds_addr_t ext_address = 0, core_location_reg;
int bad_count = 0, checks = 0, cyc = 0;
logic [7:0] n [4];
bcds_strobes u_bcds_strobes (.*);
bcds_far_end u_bcds_far_end (.clk, .go, .w, .stb(outbound_word_strobe),
	.bwo(buffered_word_outputs), .rq(transfer_request_level),
	.dl(inbound_word_lines), .cap);
initial forever #50 clk = ~clk;
always @(posedge clk)
begin
	cyc++;
	n[0] += address_taken_pulse;
	n[1] += inbound_word_strobe;
	n[2] += outbound_word_strobe;
	n[3] += core_write_start;
	if (cyc > 2000)
	begin
		bad_count++;
		complete_run;
	end
end
task check(input bcds_word_t s, input bcds_word_t e);
	checks++;
	if (s !== e)
	begin
		bad_count++;
		$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
	end
endtask
task pulse(input int k);
	p[k] = 1;
	repeat (8) @(negedge clk);
	p[k] = 0;
	repeat (8) @(negedge clk);
endtask
task xfer(input logic d, input bcds_word_t v);
	bcds_word_t old;
	old = buffered_word_outputs;
	n = '{0, 0, 0, 0};
	go = 1'h1;
	dir_into_memory = d;
	w = v;
	ext_address = v[14:0];
	instr_done = 1'h0;
	repeat (4) @(negedge clk);
	pulse(3);
	check(break_request, 1'h1);
	pulse(0);
	check(n[0], 0);
	instr_done = 1;
	pulse(0);
	check(n[0], 1);
	check(core_location_reg, v[14:0]);
	pulse(2);
	check(n[1], d);
	check(n[2], !d);
	go = 0;
	repeat (4) @(negedge clk);
	pulse(3);
	check(n[3], d);
	check(break_request, 1'h0);
	check(buffered_word_outputs, d ? v : old);
	if (!d)
		check(cap, old);
	$display("xfer done dir=%0d", d);
endtask
task reset_mid;
	resetn = 0;
	repeat (3) @(negedge clk);
	check(buffered_word_outputs, `BCDS_WORD_RST);
	check(core_location_reg, `BCDS_ADDR_RST);
	check(break_request, 1'h0);
	resetn = 1;
	repeat (4) @(negedge clk);
	$display("reset done");
endtask
task complete_run;
	$display("bad=%0d checks=%0d", bad_count, checks);
	if (bad_count == 0 && checks > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
endtask
initial
begin
	repeat (3) @(negedge clk);
	resetn = 1;
	repeat (4) @(negedge clk);
	xfer(1, 18'h2_5a5a);
	xfer(0, 18'h0_0000);
	xfer(1, 18'h3_ffff);
	xfer(0, 18'h1_0001);
	reset_mid;
	xfer(0, 18'h0_1234);
	complete_run;
end
endmodule
bind bcds_strobes bcds_strobes_monitor u_bcds_strobes_monitor (.*);

// ==== verilog/bcds_strobes.sv ====
// Purpose: data phase strobes of a cycle stealing break port
// Assumes: phase pulses, request and direction are asynchronous
// Notes: strobes are active high one-cycle pulses on clk
`include "bcds_defines.svh"
module bcds_strobes
	import bcds_pkg::*;
#(
	parameter int WORD_W = `BCDS_WORD_W,
	parameter int ADDR_W = `BCDS_ADDR_W
)
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       phase_one_pulse,
	input  wire logic       phase_two_pulse,
	input  wire logic       phase_three_pulse,
	input  wire logic       phase_five_pulse,
	input  wire logic       instr_done,
	input  wire logic       transfer_request_level,
	input  wire logic       dir_into_memory,
	input  wire bcds_addr_t ext_address,
	input  wire bcds_word_t inbound_word_lines,
	output logic            break_request,
	output logic            address_taken_pulse,
	output logic            inbound_word_strobe,
	output logic            outbound_word_strobe,
	output logic            core_write_start,
	output bcds_addr_t      core_location_reg,
	output bcds_word_t      buffered_word_outputs
);
	logic     rst1_reg;
	logic     rst2_reg;
	bcds_st_t s_reg;
	bcds_st_t s_next;
	bcds_phase_t e;
	localparam int PHASES = $bits(bcds_phase_t);
	logic [PHASES-1:0] ph_now;
	logic [PHASES-1:0] ph_old;
	logic [PHASES-1:0] ph_rise;
	// port types are fixed by the package, only the defaults serve
	if (WORD_W != $bits(bcds_word_t))
	begin : g_word_check
		$error("word width differs from the package word type");
	end
	if (ADDR_W != $bits(bcds_addr_t))
	begin : g_addr_check
		$error("address width differs from the package address type");
	end
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst1_reg <= 1'b0;
			rst2_reg <= 1'b0;
		end
		else
		begin
			rst1_reg <= 1'b1;
			rst2_reg <= rst1_reg;
		end
	end
	assign ph_now = s_reg.s2;
	assign ph_old = s_reg.s3;
	// rising edges taken from the second stage against the third
	for (genvar k = 0; k < PHASES; k++)
	begin : g_edge
		assign ph_rise[k] = ph_now[k] & ~ph_old[k];
	end
	assign e = ph_rise;
	always_comb
	begin
		s_next = s_reg;
		s_next.s1 = {phase_one_pulse, phase_two_pulse,
			phase_three_pulse, phase_five_pulse};
		s_next.s2 = s_reg.s1;
		s_next.s3 = s_reg.s2;
		s_next.req1 = transfer_request_level;
		s_next.req2 = s_reg.req1;
		s_next.dir1 = dir_into_memory;
		s_next.dir2 = s_reg.dir1;
		// lines are quasi-static, still two stages before use
		s_next.a1 = ext_address;
		s_next.a2 = s_reg.a1;
		s_next.w1 = inbound_word_lines;
		s_next.w2 = s_reg.w1;
		s_next.in_stb = 1'b0;
		s_next.out_stb = 1'b0;
		s_next.addr_stb = 1'b0;
		s_next.wr = 1'b0;
		unique case (s_reg.st)
			BCDS_IDLE:
			begin
				if (e.p5 && s_reg.req2)
				begin
					s_next.st = BCDS_SYNC;
				end
			end
			BCDS_SYNC:
			begin
				// break entered after current instruction
				if (instr_done && e.p1)
				begin
					s_next.st = BCDS_BRK;
					s_next.addr_stb = 1'b1;
					s_next.loc = s_reg.a2;
					s_next.strobed = 1'b0;
				end
			end
			BCDS_BRK:
			begin
				// direction judged once, at phase three
				if (e.p3 && !s_reg.strobed)
				begin
					s_next.strobed = 1'b1;
					s_next.dir_in = s_reg.dir2;
					if (s_reg.dir2)
					begin
						s_next.in_stb = 1'b1;
						s_next.word = s_reg.w2;
					end
					else
					begin
						s_next.out_stb = 1'b1;
					end
				end
				if (e.p5 && s_reg.strobed)
				begin
					s_next.wr = s_reg.dir_in;
					// request level re-sampled for a following break
					s_next.st = s_reg.req2 ? BCDS_SYNC : BCDS_IDLE;
				end
			end
			default:
				s_next.st = BCDS_IDLE;
		endcase
		s_next.brk_rq = (s_next.st == BCDS_SYNC);
	end
	always_ff @(posedge clk or negedge rst2_reg)
	begin
		if (!rst2_reg)
		begin
			s_reg <= '0;
			s_reg.word <= `BCDS_WORD_RST;
			s_reg.loc <= `BCDS_ADDR_RST;
		end
		else
			s_reg <= s_next;
	end
	assign break_request = s_reg.brk_rq;
	assign address_taken_pulse = s_reg.addr_stb;
	assign inbound_word_strobe = s_reg.in_stb;
	assign outbound_word_strobe = s_reg.out_stb;
	assign core_write_start = s_reg.wr;
	assign core_location_reg = s_reg.loc;
	assign buffered_word_outputs = s_reg.word;
endmodule
